// ===== design/eia_adder8.sv
// Eight-bit adder with arithmetic status outputs
`timescale 1ns/10ps
module eia_adder8 (
    input wire logic [7:0] opA,
    input wire logic [7:0] opB,
    input wire logic carryIn,
    output logic [7:0] sum,
    output logic carryOut,
    output logic halfOut,
    output logic overflowOut,
    output logic signOut,
    output logic zeroOut
);

    // ----------------------------------------
    // Sum and flag derivation
    // ----------------------------------------
    logic [8:0] full; // Nine bits keep the carry
    logic [4:0] low; // Low nibble sum gives half carry

    assign full = {1'b0, opA} + {1'b0, opB} + {8'h00, carryIn};
    assign low = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, carryIn};
    assign sum = full[7:0];
    assign carryOut = full[8];
    assign halfOut = low[4];
    // Signed overflow: equal operand signs, different result sign
    assign overflowOut = (opA[7] == opB[7]) && (full[7] != opA[7]);
    // True sign of the result, corrected for overflow
    assign signOut = full[7] ^ overflowOut;
    assign zeroOut = (full[7:0] == 8'h00);

endmodule

// ===== design/eia_exec_unit.sv
// Execution unit for extended skip, table, swap, add and AND operations
`timescale 1ns/10ps
`include "eia_defs.svh"
module eia_exec_unit
    import eia_pkg::*;
#(
    parameter int DM_AW = 10, // Data memory address bits
    parameter int PM_AW = 12 // Program memory address bits
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic start,
    input wire eia_op_type opcode,
    input wire logic [DM_AW-1:0] memAddr,
    input wire logic [2:0] bitSel,
    input wire logic [7:0] immData,
    input wire logic [PM_AW-9:0] tablePage,
    input wire logic [15:0] pmData,
    input wire logic hostWrEn,
    input wire logic [DM_AW-1:0] hostAddr,
    input wire logic [7:0] hostWrData,
    input wire logic accWrEn,
    input wire logic [7:0] accWrData,
    input wire logic carryWrData,
    input wire logic tblPtrWrEn,
    input wire logic [7:0] tblPtrWrData,
    output logic busy_r,
    output logic done_r,
    output logic skip_r,
    output logic [1:0] cycles_r,
    output logic [PM_AW-1:0] pmAddr_r,
    output logic [7:0] acc_r,
    output logic zeroFlag_r,
    output logic carryFlag_r,
    output logic nibbleHalfFlag_r,
    output logic signedRangeFlag_r,
    output logic signResultFlag_r,
    output logic [7:0] tablePtr_r,
    output logic [7:0] tableHigh_r,
    output logic pcLowWrite_r,
    output logic [7:0] pcLowData_r,
    output logic [7:0] hostRdData_r
);

    // ----------------------------------------
    // State and storage
    // ----------------------------------------
    logic [7:0] mem [0:(1<<DM_AW)-1]; // Whole data memory, all sectors
    eia_state_type state_r; // Sequencer state
    eia_op_type op_r; // Latched operation
    logic [DM_AW-1:0] addr_r; // Latched full-range address
    logic [2:0] bit_r; // Latched bit select
    logic [7:0] imm_r; // Latched immediate
    logic [1:0] cnt_r; // Current instruction cycle, from 1
    logic [1:0] nCyc_r; // Length, 3 from accept, ALU length decided at the action cycle
    logic skipHeld_r; // Skip decision kept until done

    // ----------------------------------------
    // Operand decode
    // ----------------------------------------
    logic running;
    logic accept;
    logic [7:0] memVal;
    logic bitVal;
    logic [7:0] incVal;
    logic [7:0] decVal;
    logic [7:0] swapVal;
    logic [7:0] andVal;
    logic isTable;
    logic isImm;
    logic isAdd;
    logic isAdc;
    logic isAnd;
    logic isIncOp;
    logic isDecOp;
    logic inIsInc;
    logic inIsLast;
    logic inIsTable;

    assign running = (state_r == EIA_RUN);
    assign accept = clkEn && !running && start;
    // Full address reaches every sector with no indirection
    // direct sector access
    assign memVal = mem[addr_r];
    assign bitVal = memVal[bit_r];
    assign incVal = memVal + 8'h01;
    assign decVal = memVal - 8'h01;
    assign swapVal = {memVal[`EIA_LO_NIB], memVal[`EIA_HI_NIB]};
    assign isTable = (op_r == EIA_TBL_PAGE) || (op_r == EIA_TBL_LAST)
        || (op_r == EIA_INC_TBL_PAGE) || (op_r == EIA_INC_TBL_LAST);
    assign isImm = (op_r == EIA_ADD_IMM) || (op_r == EIA_AND_IMM);
    assign isAdc = (op_r == EIA_ADC_ACC) || (op_r == EIA_ADC_MEM);
    assign isAdd = isAdc || (op_r == EIA_ADD_ACC)
        || (op_r == EIA_ADD_IMM) || (op_r == EIA_ADD_MEM);
    assign isAnd = (op_r == EIA_AND_ACC) || (op_r == EIA_AND_IMM)
        || (op_r == EIA_AND_MEM);
    assign isIncOp = (op_r == EIA_INC_SKIP) || (op_r == EIA_INC_SKIP_ACC);
    assign isDecOp = (op_r == EIA_DEC_SKIP) || (op_r == EIA_DEC_SKIP_ACC);
    assign andVal = acc_r & (isImm ? imm_r : memVal);
    assign inIsInc = (opcode == EIA_INC_TBL_PAGE)
        || (opcode == EIA_INC_TBL_LAST);
    assign inIsLast = (opcode == EIA_TBL_LAST)
        || (opcode == EIA_INC_TBL_LAST);
    assign inIsTable = inIsInc || inIsLast || (opcode == EIA_TBL_PAGE);

    // ----------------------------------------
    // Adder
    // ----------------------------------------
    logic [7:0] addSum;
    logic addCarry;
    logic addHalf;
    logic addOvf;
    logic addSign;
    logic addZero;

    // Carry-in only for the with-carry forms
    // shared adder
    eia_adder8 u_adder (
        .opA(acc_r),
        .opB(isImm ? imm_r : memVal),
        .carryIn(isAdc && carryFlag_r),
        .sum(addSum),
        .carryOut(addCarry),
        .halfOut(addHalf),
        .overflowOut(addOvf),
        .signOut(addSign),
        .zeroOut(addZero)
    );

    // ----------------------------------------
    // Skip, write and cycle decisions
    // ----------------------------------------
    logic skipTaken;
    logic memWrOp;
    logic accWrOp;
    logic [7:0] resultVal;
    logic writesPcLow;
    logic [1:0] needCyc;
    logic actAlu;
    logic actTbl;
    logic finish;

    assign skipTaken =
        ((op_r == EIA_SKIP_ZERO) && (memVal == 8'h00))
        || ((op_r == EIA_SKIP_ZERO_MOVE) && (memVal == 8'h00))
        || ((op_r == EIA_SKIP_NONZERO) && (memVal != 8'h00))
        || ((op_r == EIA_SKIP_BIT_ZERO) && !bitVal)
        || ((op_r == EIA_SKIP_BIT_NONZERO) && bitVal)
        || (isIncOp && (incVal == 8'h00))
        || (isDecOp && (decVal == 8'h00));
    assign memWrOp = (op_r == EIA_INC_SKIP) || (op_r == EIA_DEC_SKIP)
        || (op_r == EIA_SWAP) || (op_r == EIA_ADC_MEM)
        || (op_r == EIA_ADD_MEM) || (op_r == EIA_AND_MEM);
    // Only the accumulator forms of inc/dec skip touch the accumulator
    assign accWrOp = (op_r == EIA_SKIP_ZERO_MOVE)
        || (op_r == EIA_INC_SKIP_ACC) || (op_r == EIA_DEC_SKIP_ACC)
        || (op_r == EIA_SWAP_ACC) || (op_r == EIA_ADC_ACC)
        || (op_r == EIA_ADD_ACC) || (op_r == EIA_ADD_IMM)
        || (op_r == EIA_AND_ACC) || (op_r == EIA_AND_IMM);
    // One result mux feeds both the accumulator and memory
    assign resultVal = isAdd ? addSum
        : isAnd ? andVal
        : isIncOp ? incVal
        : isDecOp ? decVal
        : ((op_r == EIA_SWAP) || (op_r == EIA_SWAP_ACC)) ? swapVal
        : memVal;
    assign writesPcLow = (memWrOp || isTable)
        && (addr_r == DM_AW'(`EIA_PC_LOW_ADDR));
    // length set by skip or program counter low write
    assign needCyc = (isImm || (op_r == EIA_NOP)) ? `EIA_CYC_SHORT
        : (skipTaken || writesPcLow) ? `EIA_CYC_LONG
        : `EIA_CYC_BASE;
    assign actAlu = clkEn && running && !isTable
        && (cnt_r == `EIA_ACT_ALU);
    // Word requested at accept is valid in the second cycle
    assign actTbl = clkEn && running && isTable
        && (cnt_r == `EIA_ACT_TBL);
    assign finish = clkEn && running
        && (actAlu ? (needCyc == cnt_r) : (cnt_r == nCyc_r));

    // ----------------------------------------
    // Memory port
    // ----------------------------------------
    logic memWe;
    logic [DM_AW-1:0] memWa;
    logic [7:0] memWd;

    // Host preload only while idle, so it never races an operation
    // low byte of table word to memory
    assign memWe = (actAlu && memWrOp) || actTbl
        || (clkEn && !running && hostWrEn);
    assign memWa = running ? addr_r : hostAddr;
    assign memWd = !running ? hostWrData
        : actTbl ? pmData[`EIA_PM_LO] : resultVal;

    // Memory write, no reset on the array
    always_ff @(posedge clk) begin
        if (memWe) begin
            mem[memWa] <= memWd;
        end
    end

    // Host readback
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hostRdData_r <= 8'h00;
        end else if (clkEn) begin
            hostRdData_r <= mem[hostAddr];
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    eia_state_type state_nxt;
    logic [1:0] nCyc_nxt;

    assign state_nxt = accept ? EIA_RUN : finish ? EIA_IDLE : state_r;
    // Table reads are fixed length, ALU length chosen when it acts
    // three cycles for table reads
    assign nCyc_nxt = accept ? `EIA_CYC_LONG
        : actAlu ? needCyc : nCyc_r;

    // State, counter and latched operands
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= EIA_IDLE;
            op_r <= EIA_NOP;
            addr_r <= '0;
            bit_r <= 3'h0;
            imm_r <= 8'h00;
            cnt_r <= 2'h0;
            nCyc_r <= 2'h0;
        end else if (clkEn) begin
            state_r <= state_nxt;
            nCyc_r <= nCyc_nxt;
            if (accept) begin
                op_r <= opcode;
                addr_r <= memAddr;
                bit_r <= bitSel;
                imm_r <= immData;
                cnt_r <= 2'h1;
            end else if (running && !finish) begin
                cnt_r <= cnt_r + 2'h1;
            end
        end
    end

    // Completion status, done pulses for one cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
            skip_r <= 1'b0;
            skipHeld_r <= 1'b0;
            cycles_r <= 2'h0;
        end else if (clkEn) begin
            busy_r <= (state_nxt == EIA_RUN);
            done_r <= finish;
            if (actAlu) begin
                skipHeld_r <= skipTaken;
            end else if (accept) begin
                skipHeld_r <= 1'b0;
            end
            if (finish) begin
                skip_r <= actAlu ? skipTaken : skipHeld_r;
                cycles_r <= cnt_r;
            end
        end
    end

    // ----------------------------------------
    // Table pointer and program memory address
    // ----------------------------------------
    logic [7:0] ptrUse;
    logic [PM_AW-9:0] pageUse;

    // pointer bumped before the read uses it
    assign ptrUse = inIsInc ? tablePtr_r + 8'h01 : tablePtr_r;
    // last page is the all-ones page
    assign pageUse = inIsLast ? '1 : tablePage;

    // Pointer, address and high byte of the table word
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tablePtr_r <= `EIA_TPTR_RST;
            pmAddr_r <= '0;
            tableHigh_r <= `EIA_THIGH_RST;
        end else if (clkEn) begin
            if (accept && inIsTable) begin
                tablePtr_r <= ptrUse;
                pmAddr_r <= {pageUse, ptrUse};
            end else if (!running && tblPtrWrEn) begin
                tablePtr_r <= tblPtrWrData;
            end
            // high byte to table high register
            if (actTbl) begin
                tableHigh_r <= pmData[`EIA_PM_HI];
            end
        end
    end

    // ----------------------------------------
    // Accumulator and flags
    // ----------------------------------------
    // Accumulator written by result or by idle preload
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            acc_r <= `EIA_ACC_RST;
            pcLowWrite_r <= 1'b0;
            pcLowData_r <= 8'h00;
        end else if (clkEn) begin
            if (actAlu && accWrOp) begin
                acc_r <= resultVal;
            end else if (!running && accWrEn) begin
                acc_r <= accWrData;
            end
            // Program counter low writes announced outside
            pcLowWrite_r <= writesPcLow && ((actAlu && memWrOp) || actTbl);
            if (writesPcLow && ((actAlu && memWrOp) || actTbl)) begin
                pcLowData_r <= memWd;
            end
        end
    end

    // Adds touch five flags, AND only zero, skips none
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            zeroFlag_r <= `EIA_FLAG_RST;
            carryFlag_r <= `EIA_FLAG_RST;
            nibbleHalfFlag_r <= `EIA_FLAG_RST;
            signedRangeFlag_r <= `EIA_FLAG_RST;
            signResultFlag_r <= `EIA_FLAG_RST;
        end else if (clkEn) begin
            if (actAlu && isAdd) begin
                zeroFlag_r <= addZero;
                carryFlag_r <= addCarry;
                nibbleHalfFlag_r <= addHalf;
                signedRangeFlag_r <= addOvf;
                signResultFlag_r <= addSign;
            end else if (actAlu && isAnd) begin
                zeroFlag_r <= (andVal == 8'h00);
            end else if (!running && accWrEn) begin
                carryFlag_r <= carryWrData;
            end
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    skip_long_a: assert property (
        done_r && skip_r |-> cycles_r == 2'h3)
        else $error("skip did not take three cycles");
    noskip_two_a: assert property (
        actAlu && !skipTaken && !writesPcLow && !isImm
        && (op_r != EIA_NOP) |=> (nCyc_r == 2'h2) && (cnt_r == 2'h2))
        else $error("plain extended op not two cycles");
    pc_low_long_a: assert property (
        actAlu && writesPcLow && memWrOp |=> nCyc_r == 2'h3)
        else $error("program counter low write not three cycles");
    table_high_a: assert property (
        actTbl |=> tableHigh_r == $past(pmData[15:8]))
        else $error("table high byte wrong");
    inc_ptr_a: assert property (
        accept && inIsInc |=> tablePtr_r == $past(tablePtr_r) + 8'h01
        && pmAddr_r[7:0] == tablePtr_r)
        else $error("table pointer not bumped first");
    add_acc_a: assert property (
        actAlu && (op_r == EIA_ADD_ACC) |=>
        acc_r == 8'($past(acc_r) + $past(memVal))
        && zeroFlag_r == (acc_r == 8'h00))
        else $error("add result or zero flag wrong");
    and_flags_a: assert property (
        actAlu && isAnd |=> $stable(carryFlag_r)
        && $stable(nibbleHalfFlag_r) && $stable(signedRangeFlag_r))
        else $error("AND changed arithmetic flags");
    move_skip_a: assert property (
        actAlu && (op_r == EIA_SKIP_ZERO_MOVE) |=>
        acc_r == $past(memVal) && $stable(zeroFlag_r))
        else $error("skip-zero-move wrong");
    swap_acc_a: assert property (
        actAlu && (op_r == EIA_SWAP_ACC) |=>
        acc_r == {$past(memVal[3:0]), $past(memVal[7:4])})
        else $error("nibble swap wrong");

    skip_seen_c: cover property (done_r && skip_r);
    table_seen_c: cover property (actTbl ##1 done_r);
    adc_seen_c: cover property (actAlu && isAdc && carryFlag_r);
    pc_low_seen_c: cover property (pcLowWrite_r);

endmodule

// ===== include/eia_defs.svh
// Constants for the extended instruction execution unit
`ifndef EIA_DEFS_SVH
`define EIA_DEFS_SVH

// ----------------------------------------
// Data memory locations
// ----------------------------------------
// Program counter low register location in sector 0
`define EIA_PC_LOW_ADDR 10'h006

// ----------------------------------------
// Instruction cycle counts
// ----------------------------------------
`define EIA_CYC_SHORT 2'h1
`define EIA_CYC_BASE 2'h2
`define EIA_CYC_LONG 2'h3
// Cycle in which an ALU operation acts
`define EIA_ACT_ALU 2'h1
// Cycle in which a table read acts (word valid)
`define EIA_ACT_TBL 2'h2

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define EIA_HI_NIB 7:4
`define EIA_LO_NIB 3:0
`define EIA_PM_HI 15:8
`define EIA_PM_LO 7:0
`define EIA_ACC_RST 8'h00
`define EIA_TPTR_RST 8'h00
`define EIA_THIGH_RST 8'h00
`define EIA_FLAG_RST 1'b0

`endif

// ===== include/eia_pkg.sv
// Types for the extended instruction execution unit
package eia_pkg;

    // Operation codes presented with a start request
    typedef enum logic [4:0] {
        EIA_NOP = 5'h00,
        EIA_SKIP_ZERO = 5'h01,
        EIA_SKIP_ZERO_MOVE = 5'h02,
        EIA_SKIP_NONZERO = 5'h03,
        EIA_SKIP_BIT_ZERO = 5'h04,
        EIA_SKIP_BIT_NONZERO = 5'h05,
        EIA_INC_SKIP = 5'h06,
        EIA_DEC_SKIP = 5'h07,
        EIA_INC_SKIP_ACC = 5'h08,
        EIA_DEC_SKIP_ACC = 5'h09,
        EIA_TBL_PAGE = 5'h0A,
        EIA_TBL_LAST = 5'h0B,
        EIA_INC_TBL_PAGE = 5'h0C,
        EIA_INC_TBL_LAST = 5'h0D,
        EIA_SWAP = 5'h0E,
        EIA_SWAP_ACC = 5'h0F,
        EIA_ADC_ACC = 5'h10,
        EIA_ADC_MEM = 5'h11,
        EIA_ADD_ACC = 5'h12,
        EIA_ADD_IMM = 5'h13,
        EIA_ADD_MEM = 5'h14,
        EIA_AND_ACC = 5'h15,
        EIA_AND_IMM = 5'h16,
        EIA_AND_MEM = 5'h17
    } eia_op_type;

    // Sequencer states, one-hot
    typedef enum logic [1:0] {
        EIA_IDLE = 2'b01,
        EIA_RUN = 2'b10
    } eia_state_type;

endpackage

// ===== testbench/eia_exec_unit_bench.sv
// Self-checking bench for the extended instruction execution unit
`timescale 1ns/10ps
// Compare helper: counts every check, reports and counts each miss
`define CHK(nm, ex, got) begin \
    cmpCount++; \
    if ((got) !== (ex)) begin \
        errors++; \
        $display("mismatch %s expected %h seen %h", nm, ex, got); \
    end \
end
module eia_exec_unit_bench
    import eia_pkg::*;
;
    // ----------------------------------------
    // Stimulus table
    // ----------------------------------------
    // Row: op, mem in, acc in, carry in, imm/bit, acc out, mem out, skip, cyc
    typedef struct {
        eia_op_type op;
        logic [7:0] m, a;
        logic ci;
        logic [7:0] x, ea, em;
        logic sk;
        logic [1:0] cy;
    } eia_row_type;
    eia_row_type rows[21] = '{
        '{EIA_ADD_ACC, 8'h80, 8'h80, 1'b1, 8'h00, 8'h00, 8'h80, 1'b0, 2'h2},
        '{EIA_SKIP_ZERO, 8'h00, 8'h5A, 1'b0, 8'h00, 8'h5A, 8'h00, 1'b1, 2'h3},
        '{EIA_SKIP_ZERO, 8'h01, 8'h5A, 1'b0, 8'h00, 8'h5A, 8'h01, 1'b0, 2'h2},
        '{EIA_SKIP_NONZERO, 8'h01, 8'h5A, 1'b0, 8'h00, 8'h5A, 8'h01, 1'b1, 2'h3},
        '{EIA_SKIP_ZERO_MOVE, 8'h00, 8'h5A, 1'b0, 8'h00, 8'h00, 8'h00, 1'b1, 2'h3},
        '{EIA_SKIP_BIT_ZERO, 8'hF7, 8'h5A, 1'b0, 8'h03, 8'h5A, 8'hF7, 1'b1, 2'h3},
        '{EIA_SKIP_BIT_NONZERO, 8'hF7, 8'h5A, 1'b0, 8'h03, 8'h5A, 8'hF7, 1'b0, 2'h2},
        '{EIA_INC_SKIP, 8'hFF, 8'h5A, 1'b0, 8'h00, 8'h5A, 8'h00, 1'b1, 2'h3},
        '{EIA_DEC_SKIP, 8'h02, 8'h5A, 1'b0, 8'h00, 8'h5A, 8'h01, 1'b0, 2'h2},
        '{EIA_INC_SKIP_ACC, 8'hFF, 8'h5A, 1'b0, 8'h00, 8'h00, 8'hFF, 1'b1, 2'h3},
        '{EIA_DEC_SKIP_ACC, 8'h01, 8'h5A, 1'b0, 8'h00, 8'h00, 8'h01, 1'b1, 2'h3},
        '{EIA_SWAP, 8'h3C, 8'h5A, 1'b0, 8'h00, 8'h5A, 8'hC3, 1'b0, 2'h2},
        '{EIA_SWAP_ACC, 8'h3C, 8'h5A, 1'b0, 8'h00, 8'hC3, 8'h3C, 1'b0, 2'h2},
        '{EIA_ADC_ACC, 8'h00, 8'h7F, 1'b1, 8'h00, 8'h80, 8'h00, 1'b0, 2'h2},
        '{EIA_ADC_MEM, 8'hF0, 8'h0F, 1'b1, 8'h00, 8'h0F, 8'h00, 1'b0, 2'h2},
        '{EIA_ADD_IMM, 8'h11, 8'h08, 1'b0, 8'h08, 8'h10, 8'h11, 1'b0, 2'h1},
        '{EIA_ADD_MEM, 8'h02, 8'h01, 1'b1, 8'h00, 8'h01, 8'h03, 1'b0, 2'h2},
        '{EIA_AND_ACC, 8'h0F, 8'hF0, 1'b1, 8'h00, 8'h00, 8'h0F, 1'b0, 2'h2},
        '{EIA_AND_IMM, 8'h55, 8'hF0, 1'b0, 8'h3C, 8'h30, 8'h55, 1'b0, 2'h1},
        '{EIA_AND_MEM, 8'h0F, 8'hAA, 1'b1, 8'h00, 8'hAA, 8'h0A, 1'b0, 2'h2},
        '{EIA_NOP, 8'h11, 8'h5A, 1'b0, 8'h00, 8'h5A, 8'h11, 1'b0, 2'h1}};
    // Table read opcodes, page then last, plain then incrementing
    eia_op_type tOps[4] = '{EIA_TBL_PAGE, EIA_TBL_LAST,
                            EIA_INC_TBL_PAGE, EIA_INC_TBL_LAST};

    // ----------------------------------------
    // Design hookup
    // ----------------------------------------
    logic clk, reset, clkEn, start, hostWrEn, accWrEn, carryWrData;
    logic tblPtrWrEn;
    eia_op_type opcode;
    logic [9:0] memAddr, hostAddr; // Default ten-bit data address
    logic [2:0] bitSel;
    logic [7:0] immData, hostWrData, accWrData, tblPtrWrData;
    logic [3:0] tablePage;
    logic [15:0] pmData;
    logic busy_r, done_r, skip_r, zeroFlag_r, carryFlag_r;
    logic nibbleHalfFlag_r, signedRangeFlag_r, signResultFlag_r;
    logic pcLowWrite_r;
    logic [1:0] cycles_r;
    logic [11:0] pmAddr_r;
    logic [7:0] acc_r, tablePtr_r, tableHigh_r, pcLowData_r, hostRdData_r;
    int errors = 0, cmpCount = 0, tick = 0;
    logic [3:0] took; // Edges from accept to done
    logic seenPcLow; // Program counter low write seen
    logic [4:0] ef; // Expected {zero, carry, half, range, sign}
    logic [12:0] aRes;
    eia_row_type r;

    eia_exec_unit uut (.clk(clk), .reset(reset), .clkEn(clkEn),
        .start(start), .opcode(opcode), .memAddr(memAddr), .bitSel(bitSel),
        .immData(immData), .tablePage(tablePage), .pmData(pmData),
        .hostWrEn(hostWrEn), .hostAddr(hostAddr), .hostWrData(hostWrData),
        .accWrEn(accWrEn), .accWrData(accWrData),
        .carryWrData(carryWrData), .tblPtrWrEn(tblPtrWrEn),
        .tblPtrWrData(tblPtrWrData), .busy_r(busy_r), .done_r(done_r),
        .skip_r(skip_r), .cycles_r(cycles_r), .pmAddr_r(pmAddr_r),
        .acc_r(acc_r), .zeroFlag_r(zeroFlag_r), .carryFlag_r(carryFlag_r),
        .nibbleHalfFlag_r(nibbleHalfFlag_r),
        .signedRangeFlag_r(signedRangeFlag_r),
        .signResultFlag_r(signResultFlag_r), .tablePtr_r(tablePtr_r),
        .tableHigh_r(tableHigh_r), .pcLowWrite_r(pcLowWrite_r),
        .pcLowData_r(pcLowData_r), .hostRdData_r(hostRdData_r));

    // ----------------------------------------
    // Clock, program memory, watchdog
    // ----------------------------------------
    always #4 clk = ~clk;
    // Program word: high byte names the page, low byte the pointer
    always @(negedge clk) begin
        pmData <= {4'hC, pmAddr_r};
    end
    // Run is under two hundred cycles; ceiling leaves wide margin
    always @(posedge clk) begin
        tick++;
        if (tick == 5000) begin
            errors++;
            results();
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Reference adder: {zero, carry, half, range, sign, sum}
    function automatic logic [12:0] addRef(logic [7:0] a, b, logic c);
        logic [8:0] s;
        logic [4:0] lo;
        logic v;
        s = {1'b0, a} + {1'b0, b} + {8'h00, c};
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c};
        v = (a[7] == b[7]) && (s[7] != a[7]);
        return {s[7:0] == 8'h00, s[8], lo[4], v, s[7] ^ v, s[7:0]};
    endfunction
    // Idle loads of memory, accumulator, carry and pointer in one cycle
    task automatic idleLoad(input logic [9:0] ad, input logic [7:0] m, a,
                            input logic ci, input logic [7:0] p);
        @(negedge clk);
        hostAddr = ad;
        hostWrData = m;
        accWrData = a;
        carryWrData = ci;
        tblPtrWrData = p;
        hostWrEn = 1'b1;
        accWrEn = 1'b1;
        tblPtrWrEn = 1'b1;
        @(negedge clk);
        hostWrEn = 1'b0;
        accWrEn = 1'b0;
        tblPtrWrEn = 1'b0;
    endtask
    // Issue one operation and count edges until done, bounded
    task automatic runOp(input eia_op_type op, input logic [9:0] ad,
                         input logic [7:0] x, input logic [3:0] pg);
        opcode = op;
        memAddr = ad;
        bitSel = x[2:0];
        immData = x;
        tablePage = pg;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        took = 4'h0;
        seenPcLow = 1'b0;
        while (1) begin
            if (pcLowWrite_r === 1'b1) seenPcLow = 1'b1;
            if (done_r === 1'b1 || took >= 4'h8) break;
            @(negedge clk);
            took++;
        end
    endtask
    // Verdict, reached from the main sequence or the watchdog
    task automatic results();
        $display("comparisons %0d errors %0d", cmpCount, errors);
        if (errors == 0 && cmpCount > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {clk, clkEn, start, hostWrEn, accWrEn, tblPtrWrEn} = 6'h10;
        {carryWrData, bitSel, immData, hostWrData, accWrData} = 28'h0;
        {memAddr, hostAddr, tablePage, tblPtrWrData} = 32'h0;
        opcode = EIA_NOP;
        ef = 5'h00;
        reset = 1'b1;
        repeat (4) @(negedge clk);
        reset = 1'b0;
        `CHK("reset state", 29'h0, {acc_r, tablePtr_r, tableHigh_r,
            cycles_r, busy_r, done_r, skip_r})
        // Row loop; target sits outside sector 0, addressed directly
        foreach (rows[i]) begin
            r = rows[i];
            idleLoad(10'h2A5, r.m, r.a, r.ci, 8'h00);
            ef[3] = r.ci;
            runOp(r.op, 10'h2A5, r.x, 4'h0);
            aRes = addRef(r.a, (r.op == EIA_ADD_IMM) ? r.x : r.m,
                r.ci & (r.op inside {EIA_ADC_ACC, EIA_ADC_MEM}));
            if (r.op inside {EIA_ADC_ACC, EIA_ADC_MEM, EIA_ADD_ACC,
                             EIA_ADD_IMM, EIA_ADD_MEM}) begin
                ef = aRes[12:8];
            end
            if (r.op inside {EIA_AND_ACC, EIA_AND_IMM, EIA_AND_MEM}) begin
                ef[4] = ((r.op == EIA_AND_MEM) ? r.em : r.ea) == 8'h00;
            end
            `CHK("edges taken", {2'h0, r.cy}, took)
            `CHK("cycles", r.cy, cycles_r)
            `CHK("skip", r.sk, skip_r)
            `CHK("acc", r.ea, acc_r)
            `CHK("flags", ef, {zeroFlag_r, carryFlag_r, nibbleHalfFlag_r,
                signedRangeFlag_r, signResultFlag_r})
            @(negedge clk);
            `CHK("memory", r.em, hostRdData_r)
        end
        // Table reads with pointer at the wrap value
        for (int k = 0; k < 4; k++) begin
            idleLoad(10'h3F1, 8'h00, 8'h5A, 1'b0, 8'hFF);
            runOp(tOps[k], 10'h3F1, 8'h00, 4'h3);
            r.x = (k > 1) ? 8'h00 : 8'hFF;
            r.ci = k[0];
            `CHK("tbl cycles", 6'h0F, {took, cycles_r})
            `CHK("tbl ptr", r.x, tablePtr_r)
            `CHK("tbl addr", {r.ci ? 4'hF : 4'h3, r.x}, pmAddr_r)
            `CHK("tbl high", {4'hC, r.ci ? 4'hF : 4'h3}, tableHigh_r)
            @(negedge clk);
            `CHK("tbl low", r.x, hostRdData_r)
        end
        // Memory write landing on the program counter low location
        idleLoad(10'h006, 8'h20, 8'h10, 1'b0, 8'h00);
        runOp(EIA_ADD_MEM, 10'h006, 8'h00, 4'h0);
        `CHK("pc low timing", 6'h0F, {took, cycles_r})
        `CHK("pc low data", 9'h130, {seenPcLow, pcLowData_r})
        // Clock enable low freezes an accepted operation
        idleLoad(10'h2A5, 8'h01, 8'h01, 1'b0, 8'h00);
        opcode = EIA_ADD_IMM;
        immData = 8'h02;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        clkEn = 1'b0;
        repeat (3) @(negedge clk);
        `CHK("frozen", 9'h101, {busy_r, acc_r})
        clkEn = 1'b1;
        @(negedge clk);
        `CHK("thawed", 9'h103, {done_r, acc_r})
        // Reset in mid-instruction clears state at once
        idleLoad(10'h2A5, 8'h01, 8'h01, 1'b0, 8'h00);
        opcode = EIA_ADD_ACC;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        reset = 1'b1;
        @(negedge clk);
        `CHK("mid reset", 9'h000, {busy_r, acc_r})
        reset = 1'b0;
        results();
    end
endmodule
